/* File: core/asc_sequencer.v */
// Converter sequencer: channel choice, start sources, result storage, completion.
// Assumes an external mux, sample-and-hold and comparator; cmpHigh is asynchronous.
// Overview of operation
// - Eight-bit results from four muxed inputs, one bit per approximation step.
// - Approximation register drives DAC code; comparator decision settles each bit.
// - Fixed single mode converts selected input once into its own result register.
// - Fixed single mode flags interrupt, if enabled, after that conversion.
// - Fixed continuous mode fills four result registers in turn, then wraps.
// - Fixed continuous mode interrupts once per four completed conversions.
// - Continuous conversion runs until software stops it.
// - Auto scan converts each selected input once into its own register.
// - Auto scan interrupts only after all selected inputs are converted.
// - Auto scan with one input selected behaves as fixed single mode.
// - Start by timer trigger, software request, or chosen input edge.
`include "asc_defines.vh"
module asc_sequencer #(
    parameter CLK_DIV = `ASC_CLK_DIV
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Configuration
    input wire [1:0] convMode,
    input wire [1:0] startSrc,
    input wire [1:0] fixedChan,
    input wire [3:0] scanMask,
    input wire edgeRising,
    input wire irqEnable,
    // Start and stop
    input wire swStart,
    input wire timerTrig,
    input wire startPin,
    input wire swStop,
    input wire doneClear,
    // Analog front end
    input wire cmpHigh,
    output reg [1:0] muxSel,
    output wire [7:0] dacCode,
    // Results and status
    output reg [7:0] result0,
    output reg [7:0] result1,
    output reg [7:0] result2,
    output reg [7:0] result3,
    output reg convDone,
    output reg convIrq,
    output wire busy
);
    localparam IDLE = 3'b001;
    localparam CONV = 3'b010;
    localparam NEXT = 3'b100;

    reg [2:0] state_q;
    reg [1:0] pinSync_q;
    reg [1:0] cmpSync_q;
    reg pinLast_q;
    reg [7:0] divCnt_q;
    reg [1:0] slot_q;
    reg [3:0] pending_q;
    reg sarStart;
    wire step;
    wire [7:0] sarResult;
    wire sarDone;
    wire pinEdge;
    wire trigger;

    // Lowest pending channel in a scan mask
    function [1:0] firstChan;
        input [3:0] m;
        begin
            if (m[0]) firstChan = 2'h0;
            else if (m[1]) firstChan = 2'h1;
            else if (m[2]) firstChan = 2'h2;
            else firstChan = 2'h3;
        end
    endfunction

    // Pin and comparator come from outside this clock, two flops each
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinSync_q <= 2'h0;
            cmpSync_q <= 2'h0;
            pinLast_q <= 1'b0;
        end else begin
            pinSync_q <= {pinSync_q[0], startPin};
            cmpSync_q <= {cmpSync_q[0], cmpHigh};
            pinLast_q <= pinSync_q[1];
        end
    end

    assign pinEdge = edgeRising ? (pinSync_q[1] & ~pinLast_q) : (~pinSync_q[1] & pinLast_q);
    // Choose the start source
    assign trigger = (startSrc == `ASC_START_TIMER) ? timerTrig :
                     (startSrc == `ASC_START_IMMEDIATE) ? swStart :
                     (startSrc == `ASC_START_EDGE) ? pinEdge : 1'b0;

    // Converter clock divider; each tick allows one approximation step.
    // Divider only runs mid-conversion so every conversion takes the same time.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divCnt_q <= 8'h00;
        end else if (state_q != CONV || divCnt_q == CLK_DIV[7:0] - 8'h01) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end
    assign step = (state_q == CONV) && (divCnt_q == CLK_DIV[7:0] - 8'h01);

    asc_sar_step #(
        .WIDTH(`ASC_DATA_BITS)
    ) u_sar (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(sarStart),
        .step(step),
        .cmpHigh(cmpSync_q[1]),
        .dacCode(dacCode),
        .result(sarResult),
        .done(sarDone)
    );

    assign busy = (state_q != IDLE);

    // Sequencer: starts, stores results, counts groups, raises completion
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= IDLE;
            muxSel <= 2'h0;
            slot_q <= 2'h0;
            pending_q <= 4'h0;
            sarStart <= 1'b0;
            result0 <= `ASC_RESET_CODE;
            result1 <= `ASC_RESET_CODE;
            result2 <= `ASC_RESET_CODE;
            result3 <= `ASC_RESET_CODE;
            convDone <= 1'b0;
            convIrq <= 1'b0;
        end else begin
            sarStart <= 1'b0;
            convIrq <= 1'b0;
            if (doneClear) begin
                convDone <= 1'b0;
            end
            case (state_q)
                IDLE: begin
                    if (trigger) begin
                        slot_q <= 2'h0;
                        if (convMode == `ASC_MODE_SCAN_SINGLE) begin
                            if (scanMask != 4'h0) begin
                                pending_q <= scanMask;
                                muxSel <= firstChan(scanMask);
                                sarStart <= 1'b1;
                                state_q <= CONV;
                            end
                        end else begin
                            muxSel <= fixedChan;
                            sarStart <= 1'b1;
                            state_q <= CONV;
                        end
                    end
                end
                CONV: begin
                    if (swStop && convMode == `ASC_MODE_FIXED_CONT) begin
                        state_q <= IDLE;
                    end else if (sarDone) begin
                        // Store by channel, or by rotating slot when continuous
                        case ((convMode == `ASC_MODE_FIXED_CONT) ? slot_q : muxSel)
                            2'h0: result0 <= sarResult;
                            2'h1: result1 <= sarResult;
                            2'h2: result2 <= sarResult;
                            default: result3 <= sarResult;
                        endcase
                        state_q <= NEXT;
                    end
                end
                NEXT: begin
                    if (convMode == `ASC_MODE_FIXED_CONT) begin
                        slot_q <= slot_q + 2'h1;
                        if (slot_q == 2'h3) begin
                            convDone <= 1'b1;
                            convIrq <= irqEnable;
                        end
                        if (swStop) begin
                            state_q <= IDLE;
                        end else begin
                            sarStart <= 1'b1;
                            state_q <= CONV;
                        end
                    end else if (convMode == `ASC_MODE_SCAN_SINGLE &&
                                 (pending_q & ~(4'h1 << muxSel)) != 4'h0) begin
                        pending_q <= pending_q & ~(4'h1 << muxSel);
                        muxSel <= firstChan(pending_q & ~(4'h1 << muxSel));
                        sarStart <= 1'b1;
                        state_q <= CONV;
                    end else begin
                        pending_q <= 4'h0;
                        convDone <= 1'b1;
                        convIrq <= irqEnable;
                        state_q <= IDLE;
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end
endmodule // asc_sequencer

/* File: pkg/asc_defines.vh */
// Constants for the converter sequencer: modes, start sources, timing.
// Assumes inclusion by bare name from the design files.
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// Conversion modes
`define ASC_MODE_FIXED_SINGLE 2'h0
`define ASC_MODE_FIXED_CONT 2'h1
`define ASC_MODE_SCAN_SINGLE 2'h2

// Start sources
`define ASC_START_TIMER 2'h0
`define ASC_START_IMMEDIATE 2'h1
`define ASC_START_EDGE 2'h2

// Data width and channel count
`define ASC_DATA_BITS 8
`define ASC_CHANNELS 4

// Converter clock divider default and result reset code
`define ASC_CLK_DIV 3
`define ASC_RESET_CODE 8'h00

`endif

/* File: core/asc_sar_step.v */
// Successive approximation engine: one result bit per step.
// Assumes the comparator decision is already synchronised to ref_clk.
`include "asc_defines.vh"
module asc_sar_step #(
    parameter WIDTH = `ASC_DATA_BITS
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Control
    input wire start,
    input wire step,
    // Analog side
    input wire cmpHigh,
    output reg [WIDTH-1:0] dacCode,
    // Result
    output reg [WIDTH-1:0] result,
    output reg done
);
    reg [WIDTH-1:0] trialBit;
    reg busy;

    // Try each bit from the top; keep it if the sample is above the DAC level
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dacCode <= {WIDTH{1'b0}};
            trialBit <= {WIDTH{1'b0}};
            result <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                trialBit <= {1'b1, {(WIDTH-1){1'b0}}};
                dacCode <= {1'b1, {(WIDTH-1){1'b0}}};
                busy <= 1'b1;
            end else if (busy && step) begin
                if (trialBit == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    result <= cmpHigh ? dacCode : (dacCode & ~trialBit);
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    // Settle this bit from the comparator, then raise the next
                    dacCode <= (cmpHigh ? dacCode : (dacCode & ~trialBit))
                        | (trialBit >> 1);
                    trialBit <= trialBit >> 1;
                end
            end
        end
    end
endmodule // asc_sar_step

/* File: dv/asc_seq_sva.sv */
// Checker for the converter sequencer, watching only its ports.
// Assumes a bind onto asc_sequencer and a single clock domain.
module asc_seq_sva (
    input wire ref_clk,
    input wire rst,
    input wire [1:0] convMode,
    input wire [1:0] startSrc,
    input wire [1:0] fixedChan,
    input wire [3:0] scanMask,
    input wire irqEnable,
    input wire swStart,
    input wire swStop,
    input wire doneClear,
    input wire [1:0] muxSel,
    input wire [7:0] dacCode,
    input wire convDone,
    input wire convIrq,
    input wire busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Interrupt and status pairing
    a_irq_gated: assert property (convIrq |-> $past(irqEnable))
        else $error("interrupt while disabled");
    a_irq_sets_done: assert property (convIrq |-> convDone)
        else $error("interrupt without done flag");
    a_irq_one_pulse: assert property (convIrq |=> !convIrq)
        else $error("interrupt longer than one cycle");
    a_done_sticky: assert property (convDone && !doneClear |=> convDone)
        else $error("done flag dropped");
    // Start, search and channel choice
    a_sw_start: assert property (!busy && startSrc == 2'h1 && swStart &&
        (convMode != 2'h2 || scanMask != 4'h0) |=> busy) else $error("start missed");
    a_msb_first: assert property ($rose(busy) |-> ##[1:3] dacCode == 8'h80)
        else $error("search not from midscale");
    a_single_len: assert property ($rose(busy) && convMode == 2'h0 |-> ##[20:40] $fell(busy))
        else $error("single conversion length wrong");
    a_fixed_chan: assert property (busy && convMode != 2'h2 |-> muxSel == fixedChan)
        else $error("wrong fixed channel");
    a_scan_chan: assert property (busy && convMode == 2'h2 |-> scanMask[muxSel])
        else $error("unselected channel scanned");
    a_stop_cont: assert property (busy && convMode == 2'h1 && swStop |-> ##[1:40] !busy)
        else $error("continuous run not stopped");
endmodule // asc_seq_sva

bind asc_sequencer asc_seq_sva u_sva (.ref_clk, .rst, .convMode, .startSrc, .fixedChan,
    .scanMask, .irqEnable, .swStart, .swStop, .doneClear, .muxSel, .dacCode, .convDone,
    .convIrq, .busy);

/* File: dv/asc_front_model.sv */
// Behavioural mux, held sample and comparator facing the sequencer.
// Assumes levels holds one byte per channel, channel 0 lowest.
module asc_front_model (
    input wire [1:0] muxSel,
    input wire [7:0] dacCode,
    input wire [31:0] levels,
    output logic cmpHigh
);
    timeunit 1ns;
    timeprecision 1ns;
    // Level sits half a code up, so a tie with the trial code never occurs
    assign cmpHigh = {levels[muxSel*8 +: 8], 1'b1} > {dacCode, 1'b0};
endmodule // asc_front_model

/* File: dv/testbench.sv */
// Self-checking bench for the converter sequencer.
// Assumes the comparator model in asc_front_model and the bound checker.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, edgeRising = 1'b1, irqEnable = 1'b1;
    logic swStart = 1'b0, timerTrig = 1'b0, startPin = 1'b0, swStop = 1'b0, doneClear = 1'b0;
    logic [1:0] convMode = 2'h0, startSrc = 2'h3, fixedChan = 2'h0;
    logic [3:0] scanMask = 4'h0;
    logic [31:0] levels = 32'h7fff8001;
    wire cmpHigh, convDone, convIrq, busy;
    wire [1:0] muxSel;
    wire [7:0] dacCode, result0, result1, result2, result3;
    int fails = 0, n_compared = 0;
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    asc_sequencer #(.CLK_DIV(3)) uut (.ref_clk, .rst, .convMode, .startSrc, .fixedChan,
        .scanMask, .edgeRising, .irqEnable, .swStart, .timerTrig, .startPin, .swStop,
        .doneClear, .cmpHigh, .muxSel, .dacCode, .result0, .result1, .result2, .result3,
        .convDone, .convIrq, .busy);
    asc_front_model u_front (.muxSel, .dacCode, .levels, .cmpHigh);
    task conclude;
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Configure, then raise the timer or software trigger for one cycle, or toggle the start pin
    task fire(input logic [1:0] m, s, ch, input logic [3:0] mk);
        convMode <= m; startSrc <= s; fixedChan <= ch; scanMask <= mk;
        @(posedge ref_clk);
        if (s == 2'h0) timerTrig <= 1'b1;
        else if (s == 2'h1) swStart <= 1'b1;
        else startPin <= ~startPin;
        @(posedge ref_clk);
        timerTrig <= 1'b0; swStart <= 1'b0;
    endtask
    // Pin starts pass a synchroniser, so busy is not expected at once
    task waitIdle(output int irqs);
        int k;
        irqs = 0; k = 0;
        do begin
            @(posedge ref_clk);
            if (convIrq === 1'b1) irqs++;
            k++;
            if (k > 400) begin fails++; conclude; end
        end while (busy !== 1'b0 || k < 6);
    endtask
    // Returns at the edge that sees the pulse, so a level change lands before the next sample
    task waitIrq(output int cyc);
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
            if (cyc > 1000) begin fails++; conclude; end
        end while (convIrq !== 1'b1);
    endtask
    task s_single(input logic en);
        int n;
        irqEnable <= en; doneClear <= 1'b1;
        @(posedge ref_clk);
        doneClear <= 1'b0;
        fire(2'h0, 2'h1, 2'h2, 4'h0);
        waitIdle(n);
        chk(32'h00ff0000, {result3, result2, result1, result0});
        chk({31'h0, en}, n);
        chk(32'h1, {31'h0, convDone});
    endtask
    task s_cont;
        int c;
        irqEnable <= 1'b1;
        fire(2'h1, 2'h0, 2'h1, 4'h0);
        waitIrq(c);
        levels[15:8] <= 8'h3c;
        waitIrq(c);
        chk(32'h1, {31'h0, c > 90});
        chk(32'h3c3c3c3c, {result3, result2, result1, result0});
        chk(32'h1, {31'h0, busy});
        swStop <= 1'b1;
        waitIdle(c);
        swStop <= 1'b0;
        chk(32'h0, {31'h0, busy});
    endtask
    // Rising edge scans two inputs; falling edge scans one input alone
    task s_scan;
        int n;
        levels <= 32'h7fff8001; edgeRising <= 1'b1;
        fire(2'h2, 2'h2, 2'h0, 4'ha);
        waitIdle(n);
        chk(32'h7f3c803c, {result3, result2, result1, result0});
        chk(32'h1, n);
        edgeRising <= 1'b0;
        fire(2'h2, 2'h2, 2'h0, 4'h1);
        waitIdle(n);
        chk(32'h7f3c8001, {result3, result2, result1, result0});
        chk(32'h1, n);
    endtask
    // Main sequence after a 16 cycle reset
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        s_single(1'b1);
        s_single(1'b0);
        s_cont;
        s_scan;
        conclude;
    end
endmodule // testbench
